//--- logic/lcbv_pkg.sv
// Constants, codes and carriers for the compensation and boot voltage registers
package lcbv_pkg;

    // ==========================================
    // Command codes
    localparam logic [7:0] LCBV_CMD_COMP = 8'hd4;
    localparam logic [7:0] LCBV_CMD_BOOT = 8'hd5;

    // ==========================================
    // Compensation word layout
    localparam int LCBV_GAIN_LSB = 12;
    localparam int LCBV_FORCE_BIT = 7;
    localparam int LCBV_INT_LSB = 3;
    localparam int LCBV_RAMP_LSB = 0;
    localparam logic [15:0] LCBV_COMP_RO_MASK = 16'h0f44;

    // ==========================================
    // Boot word layout
    localparam int LCBV_SPARE_LSB = 14;
    localparam int LCBV_CODE_LSB = 0;
    localparam logic [15:0] LCBV_BOOT_RO_MASK = 16'h3fe0;

    // ==========================================
    // Reset values, overwritten by the restore pulse
    localparam logic [15:0] LCBV_COMP_RST = 16'h0000;
    localparam logic [15:0] LCBV_BOOT_RST = 16'h0000;

    // ==========================================
    // Slew divider terminal count; the step period is this plus one core cycle
    localparam logic [7:0] LCBV_SLEW_DIV = 8'hc7;

    // Margin selection
    localparam logic [1:0] LCBV_MARGIN_NONE = 2'h0;
    localparam logic [1:0] LCBV_MARGIN_HIGH = 2'h1;
    localparam logic [1:0] LCBV_MARGIN_LOW = 2'h2;

    // Live switching frequency setting
    typedef enum logic [2:0] {
        LCBV_FSW_400K = 3'h0,
        LCBV_FSW_600K = 3'h1,
        LCBV_FSW_800K = 3'h2,
        LCBV_FSW_1M = 3'h3,
        LCBV_FSW_1M2 = 3'h4,
        LCBV_FSW_1M4 = 3'h5,
        LCBV_FSW_1M8 = 3'h6,
        LCBV_FSW_2M = 3'h7
    } lcbv_fsw_t;

    // Word transaction from the bus protocol layer
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] cmd;
        logic [15:0] data;
    } lcbv_req_t;

    // Answer to a word transaction
    typedef struct packed {
        logic valid;
        logic ack;
        logic nack;
        logic [15:0] data;
    } lcbv_resp_t;

    // Nonvolatile backup words
    typedef struct packed {
        logic [15:0] comp;
        logic [15:0] boot;
    } lcbv_nvm_t;

endpackage

//--- logic/lcbv_regs.sv
// Compensation and boot voltage command registers
`timescale 1ns/1ps

// Function
// R1: Codes d4 and d5, word read/write
// R2: Bits 15:12 hold loop AC gain
// R3: Unsupported bits always read zero
// R4: Read-only compensation bits ignore writes
// R5: Force clear: integrator time follows frequency
// R6: Frequency lookup gives integrator time codes
// R7: Force set: writable, loaded from backup
// R8: Bits 5:3 hold integrator time constant
// R9: Bits 1:0 hold ramp amplitude
// R10: Boot bits 4:0 are DAC target
// R11: Host picks scale matching boot code
// R12: Effective boot from code, scale, margins, trim
// R13: Boot code writable in every state
// R14: Soft-start target slews to new boot
// R15: Changing boot bits 13:5 is invalid
// R16: Invalid data: NACK, discard, set flags
// R17: Boot codes map to DAC voltages
// R18: Restore loads backups, writes act immediately
module lcbv_regs
    import lcbv_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Word transactions
    input wire lcbv_req_t req,
    output lcbv_resp_t resp_r,
    // Nonvolatile restore
    input wire logic nvm_load,
    input wire lcbv_nvm_t nvm,
    // Converter state
    input wire lcbv_fsw_t fsw_live,
    input wire logic soft_start,
    input wire logic [3:0] scale_mult,
    input wire logic [1:0] margin_sel,
    input wire logic [10:0] margin_high_target,
    input wire logic [10:0] margin_low_target,
    input wire logic [10:0] trim_offset,
    // Loop settings
    output logic [3:0] gain_r,
    output logic [2:0] int_time_r,
    output logic [1:0] ramp_r,
    // Boot voltage
    output logic [10:0] boot_dac_voltage_r,
    output logic [15:0] boot_voltage_r,
    output logic [15:0] ref_target_r,
    // Status set pulses
    output logic cml_fault_set_r,
    output logic invalid_data_set_r
);

    // ==========================================
    // Functions
    function automatic logic [2:0] int_lookup(input lcbv_fsw_t f);
        case (f) // R6
            LCBV_FSW_400K: int_lookup = 3'h7;
            LCBV_FSW_600K: int_lookup = 3'h6;
            LCBV_FSW_800K: int_lookup = 3'h4;
            LCBV_FSW_1M: int_lookup = 3'h4;
            LCBV_FSW_1M2: int_lookup = 3'h3;
            LCBV_FSW_1M4: int_lookup = 3'h3;
            LCBV_FSW_1M8: int_lookup = 3'h2;
            default: int_lookup = 3'h2;
        endcase
    endfunction

    // Voltage in units of 1/2048 V
    function automatic logic [10:0] dac_volt(input logic [4:0] c);
        case (c) // R17
            5'h00: dac_volt = 11'h000;
            5'h01: dac_volt = 11'h266;
            5'h02: dac_volt = 11'h280;
            5'h03: dac_volt = 11'h29a;
            5'h04: dac_volt = 11'h2b4;
            5'h05: dac_volt = 11'h2cd;
            5'h06: dac_volt = 11'h2e6;
            5'h07: dac_volt = 11'h300;
            5'h08: dac_volt = 11'h31a;
            5'h09: dac_volt = 11'h333;
            5'h0a: dac_volt = 11'h34d;
            5'h0b: dac_volt = 11'h366;
            5'h0c: dac_volt = 11'h380;
            5'h0d: dac_volt = 11'h39a;
            5'h0e: dac_volt = 11'h3b4;
            5'h0f: dac_volt = 11'h3cd;
            5'h10: dac_volt = 11'h3e6;
            5'h11: dac_volt = 11'h400;
            5'h12: dac_volt = 11'h41a;
            5'h13: dac_volt = 11'h433;
            5'h14: dac_volt = 11'h44c;
            5'h15: dac_volt = 11'h466;
            5'h16: dac_volt = 11'h480;
            5'h17: dac_volt = 11'h49a;
            5'h18: dac_volt = 11'h4b4;
            5'h19: dac_volt = 11'h4cc;
            5'h1a: dac_volt = 11'h500;
            5'h1b: dac_volt = 11'h533;
            5'h1c: dac_volt = 11'h566;
            5'h1d: dac_volt = 11'h59a;
            5'h1e: dac_volt = 11'h5cc;
            default: dac_volt = 11'h600;
        endcase
    endfunction

    // Sum wraps at 11 bits before the product; a cast alone leaves the width to the tool
    function automatic logic [15:0] scaled(input logic [10:0] v, input logic [10:0] t,
        input logic [3:0] m);
        logic [10:0] sum;
        sum = v + t;
        scaled = {5'h00, sum} * {12'h000, m};
    endfunction

    // One LSB toward the goal, or hold
    function automatic logic [15:0] step_toward(input logic [15:0] cur, input logic [15:0] goal);
        if (cur < goal) begin
            step_toward = cur + 16'h0001;
        end else if (cur > goal) begin
            step_toward = cur - 16'h0001;
        end else begin
            step_toward = cur;
        end
    endfunction

    // Read words with read-only spans forced to zero
    function automatic logic [15:0] pack_comp(input logic [3:0] g, input logic f,
        input logic [2:0] it, input logic [1:0] rp);
        pack_comp = {g, 4'h0, f, 1'b0, it, 1'b0, rp};
    endfunction

    function automatic logic [15:0] pack_boot(input logic [1:0] sp, input logic [4:0] cd);
        pack_boot = {sp, 9'h000, cd};
    endfunction

    // ==========================================
    // Stored fields
    logic force_r;
    logic [2:0] int_store_r;
    logic [1:0] spare_r;
    logic [4:0] boot_code_r;
    logic [7:0] slew_cnt_r;
    logic slew_step_r;
    logic [15:0] comp_word;
    logic [15:0] boot_word;
    logic wr_comp;
    logic wr_boot;
    logic hit_comp;
    logic hit_boot;
    logic boot_bad;

    assign wr_comp = req.valid && req.write && req.cmd == LCBV_CMD_COMP;
    assign wr_boot = req.valid && req.write && req.cmd == LCBV_CMD_BOOT;
    // Foreign codes hit neither and get no answer
    assign hit_comp = req.valid && req.cmd == LCBV_CMD_COMP; // R1
    assign hit_boot = req.valid && req.cmd == LCBV_CMD_BOOT; // R1
    // Any set bit in the read-only span counts as an attempted change
    assign boot_bad = (req.data & LCBV_BOOT_RO_MASK) != 16'h0000; // R15

    assign comp_word = pack_comp(gain_r, force_r, int_time_r, ramp_r); // R3
    assign boot_word = pack_boot(spare_r, boot_code_r); // R3

    // ==========================================
    // Compensation fields, one process each
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_r <= LCBV_COMP_RST[15:12];
        end else if (nvm_load) begin // R18
            gain_r <= nvm.comp[LCBV_GAIN_LSB +: 4];
        end else if (wr_comp) begin // R1
            // Masked bits simply are not stored
            gain_r <= req.data[LCBV_GAIN_LSB +: 4]; // R2 R4
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            force_r <= LCBV_COMP_RST[7];
        end else if (nvm_load) begin // R18
            force_r <= nvm.comp[LCBV_FORCE_BIT];
        end else if (wr_comp) begin
            force_r <= req.data[LCBV_FORCE_BIT]; // R5 R7
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ramp_r <= LCBV_COMP_RST[1:0];
        end else if (nvm_load) begin // R18
            ramp_r <= nvm.comp[LCBV_RAMP_LSB +: 2];
        end else if (wr_comp) begin
            ramp_r <= req.data[LCBV_RAMP_LSB +: 2]; // R9
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_store_r <= LCBV_COMP_RST[5:3];
        end else if (nvm_load) begin
            int_store_r <= nvm.comp[LCBV_INT_LSB +: 3]; // R18
        end else if (wr_comp && force_r && req.data[LCBV_FORCE_BIT]) begin
            int_store_r <= req.data[LCBV_INT_LSB +: 3]; // R7 R8
        end else if (wr_comp && !force_r && req.data[LCBV_FORCE_BIT]) begin
            int_store_r <= nvm.comp[LCBV_INT_LSB +: 3]; // R7
        end
    end

    // Field read-only and lookup-driven while force is clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_time_r <= LCBV_COMP_RST[5:3];
        end else begin
            int_time_r <= force_r ? int_store_r : int_lookup(fsw_live); // R5
        end
    end

    // ==========================================
    // Boot fields, no state locks them
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            spare_r <= LCBV_BOOT_RST[15:14];
        end else if (nvm_load) begin
            spare_r <= nvm.boot[LCBV_SPARE_LSB +: 2]; // R18
        end else if (wr_boot && !boot_bad) begin // R16
            spare_r <= req.data[LCBV_SPARE_LSB +: 2];
        end
    end

    // A refused word leaves the code untouched
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_code_r <= LCBV_BOOT_RST[4:0];
        end else if (nvm_load) begin
            boot_code_r <= nvm.boot[LCBV_CODE_LSB +: 5]; // R18
        end else if (wr_boot && !boot_bad) begin // R13 R16
            boot_code_r <= req.data[LCBV_CODE_LSB +: 5]; // R10
        end
    end

    // ==========================================
    // Boot voltage computation
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_dac_voltage_r <= 11'h000;
        end else begin
            boot_dac_voltage_r <= dac_volt(boot_code_r); // R17
        end
    end

    // Scale factor is the host's choice; no range check here
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_voltage_r <= 16'h0000;
        end else if (margin_sel == LCBV_MARGIN_HIGH) begin
            boot_voltage_r <= scaled(margin_high_target, trim_offset, scale_mult); // R12
        end else if (margin_sel == LCBV_MARGIN_LOW) begin
            boot_voltage_r <= scaled(margin_low_target, trim_offset, scale_mult); // R12
        end else begin
            boot_voltage_r <= scaled(boot_dac_voltage_r, trim_offset, scale_mult); // R11 R12
        end
    end

    // ==========================================
    // Reference target slew
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slew_cnt_r <= 8'h00;
        end else if (slew_cnt_r == LCBV_SLEW_DIV) begin
            slew_cnt_r <= 8'h00;
        end else begin
            slew_cnt_r <= slew_cnt_r + 8'h01;
        end
    end

    // Divider pulse, one cycle in every period
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slew_step_r <= 1'b0;
        end else begin
            slew_step_r <= slew_cnt_r == LCBV_SLEW_DIV;
        end
    end

    // One LSB per step keeps the ramp monotonic in soft-start
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_target_r <= 16'h0000;
        end else if (!soft_start) begin
            ref_target_r <= boot_voltage_r;
        end else if (slew_step_r) begin
            ref_target_r <= step_toward(ref_target_r, boot_voltage_r); // R14
        end
    end

    // ==========================================
    // Answers and status pulses
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_r <= '0;
        end else if (hit_comp) begin
            resp_r.valid <= 1'b1;
            resp_r.ack <= 1'b1;
            resp_r.nack <= 1'b0;
            resp_r.data <= req.write ? 16'h0000 : comp_word;
        end else if (hit_boot) begin
            resp_r.valid <= 1'b1;
            resp_r.ack <= !(req.write && boot_bad);
            resp_r.nack <= req.write && boot_bad; // R16
            resp_r.data <= req.write ? 16'h0000 : boot_word;
        end else begin
            resp_r <= '0;
        end
    end

    // Pulses only; the status flags they set live outside
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cml_fault_set_r <= 1'b0;
        end else begin
            cml_fault_set_r <= wr_boot && boot_bad; // R16
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            invalid_data_set_r <= 1'b0;
        end else begin
            invalid_data_set_r <= wr_boot && boot_bad; // R16
        end
    end

endmodule

//--- bench/lcbv_regs_properties.sv
// Assertions on the command register ports
`timescale 1ns/1ps
module lcbv_regs_properties
    import lcbv_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Bus and state
    input wire lcbv_req_t req,
    input wire lcbv_resp_t resp_r,
    input wire logic nvm_load,
    input wire logic soft_start,
    // Results
    input wire logic [3:0] gain_r,
    input wire logic [1:0] ramp_r,
    input wire logic [15:0] boot_voltage_r,
    input wire logic [15:0] ref_target_r,
    input wire logic cml_fault_set_r,
    input wire logic invalid_data_set_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic ours = req.valid && (req.cmd == LCBV_CMD_COMP || req.cmd == LCBV_CMD_BOOT);
    wire logic cw = req.valid && req.write && req.cmd == LCBV_CMD_COMP;
    wire logic bad = req.valid && req.write && req.cmd == LCBV_CMD_BOOT
        && |(req.data & LCBV_BOOT_RO_MASK);
    sequence s_bad;
        bad;
    endsequence
    sequence s_nack;
        resp_r.nack && !resp_r.ack && cml_fault_set_r && invalid_data_set_r;
    endsequence
    AST_ANSWER: assert property (ours |=> resp_r.valid)
        else $error("No answer");
    AST_SILENT: assert property (!ours |=> !resp_r.valid)
        else $error("Answer without request");
    AST_NACK: assert property (s_bad |=> s_nack)
        else $error("Bad boot write not refused");
    AST_FLAG: assert property ((cml_fault_set_r || invalid_data_set_r) |-> resp_r.nack)
        else $error("Flag without refusal");
    AST_COMP_ACK: assert property (cw |=> resp_r.ack && !resp_r.nack)
        else $error("Comp write refused");
    AST_RO_ZERO: assert property (resp_r.valid && !$past(req.write) |->
        (resp_r.data & ($past(req.cmd) == LCBV_CMD_COMP ? LCBV_COMP_RO_MASK
        : LCBV_BOOT_RO_MASK)) == 16'h0000) else $error("Read-only bit set");
    AST_GAIN: assert property (cw && !nvm_load |=> gain_r == $past(req.data[15:12])
        && ramp_r == $past(req.data[1:0])) else $error("Field not stored");
    AST_TRACK: assert property (!soft_start |=> ref_target_r == $past(boot_voltage_r))
        else $error("Target not following");
    AST_SLEW: assert property ($past(soft_start) |-> ref_target_r == $past(ref_target_r)
        || ref_target_r == $past(ref_target_r) + 16'h0001
        || ref_target_r == $past(ref_target_r) - 16'h0001) else $error("Slew step");
endmodule
bind lcbv_regs lcbv_regs_properties u_lcbv_regs_properties(.core_clk(core_clk),
    .sys_rst(sys_rst), .req(req), .resp_r(resp_r), .nvm_load(nvm_load),
    .soft_start(soft_start), .gain_r(gain_r), .ramp_r(ramp_r),
    .boot_voltage_r(boot_voltage_r), .ref_target_r(ref_target_r),
    .cml_fault_set_r(cml_fault_set_r), .invalid_data_set_r(invalid_data_set_r));

//--- bench/lcbv_host.sv
// Host controller model issuing word transactions
`timescale 1ns/1ps
module lcbv_host
    import lcbv_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Requests
    output lcbv_req_t req
);
    initial req = '0;
    // Idle lines flip so stale data never looks valid
    task automatic word(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge core_clk);
        req <= '{1'b1, w, c, d};
        @(posedge core_clk);
        req <= '{1'b0, ~w, ~c, ~d};
    endtask
endmodule

//--- bench/lcbv_regs_bench.sv
// Self-checking bench for the command registers
`timescale 1ns/1ps
module lcbv_regs_bench;
    import lcbv_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic nvm_load = 1'b0;
    logic soft_start = 1'b0;
    lcbv_nvm_t nvm = '0;
    lcbv_fsw_t fsw_live = LCBV_FSW_400K;
    logic [3:0] scale_mult = 4'h1;
    logic [1:0] margin_sel = 2'h0;
    logic [10:0] mhi = 11'h000, mlo = 11'h000, trim = 11'h000, s;
    lcbv_req_t req;
    lcbv_resp_t resp_r;
    logic [3:0] gain_r;
    logic [2:0] int_time_r;
    logic [1:0] ramp_r;
    logic [10:0] boot_dac_voltage_r;
    logic [15:0] boot_voltage_r, ref_target_r, d, e;
    logic cml_fault_set_r, invalid_data_set_r;
    logic [18:0] q[$];
    logic [18:0] n;
    int mismatches = 0;
    int n_checks = 0;
    integer seed = 32'h22a13516;
    always #2.5 core_clk = ~core_clk;
    lcbv_host u_lcbv_host(.core_clk(core_clk), .req(req));
    lcbv_regs u_lcbv_regs(.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
        .resp_r(resp_r), .nvm_load(nvm_load), .nvm(nvm), .fsw_live(fsw_live),
        .soft_start(soft_start), .scale_mult(scale_mult), .margin_sel(margin_sel),
        .margin_high_target(mhi), .margin_low_target(mlo), .trim_offset(trim),
        .gain_r(gain_r), .int_time_r(int_time_r), .ramp_r(ramp_r),
        .boot_dac_voltage_r(boot_dac_voltage_r), .boot_voltage_r(boot_voltage_r),
        .ref_target_r(ref_target_r), .cml_fault_set_r(cml_fault_set_r),
        .invalid_data_set_r(invalid_data_set_r));
    // ==========================================
    // Checking
    task automatic chk(input logic [17:0] sn, input logic [17:0] ex);
        n_checks++;
        if (sn !== ex) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, sn, ex);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Write answers carry no data, so only the code is compared
    always @(posedge core_clk) begin
        if (resp_r.valid === 1'b1) begin
            n = (q.size() > 0) ? q.pop_front() : 19'h7ffff;
            chk({resp_r.ack, resp_r.nack, resp_r.data & {16{n[18]}}}, n[17:0]);
        end
    end
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] dd,
        input logic [17:0] ex);
        q.push_back({!w, ex});
        u_lcbv_host.word(w, c, dd);
    endtask
    function automatic logic [2:0] lut(input int f);
        case (f)
            0: lut = 3'h7;
            1: lut = 3'h6;
            2, 3: lut = 3'h4;
            4, 5: lut = 3'h3;
            default: lut = 3'h2;
        endcase
    endfunction
    function automatic logic [10:0] dac(input int c);
        dac = (c == 0) ? 11'h000 : (c == 1) ? 11'h266 : 11'h280;
    endfunction
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        nvm <= '{16'h9fff, 16'hffff};
        nvm_load <= 1'b1;
        @(posedge core_clk);
        nvm_load <= 1'b0;
        acc(1'b0, LCBV_CMD_COMP, 16'h0000, {2'h2, 16'h90bb});
        acc(1'b0, LCBV_CMD_BOOT, 16'h0000, {2'h2, 16'hc01f});
        for (int i = 0; i < 8; i++) begin
            d = 16'($random(seed)) | 16'h0080;
            acc(1'b1, LCBV_CMD_COMP, d, {2'h2, 16'h0000});
            acc(1'b0, LCBV_CMD_COMP, 16'h0000, {2'h2, d & ~LCBV_COMP_RO_MASK});
        end
        d = 16'($random(seed)) & 16'hff7f;
        acc(1'b1, LCBV_CMD_COMP, d, {2'h2, 16'h0000});
        for (int f = 0; f < 8; f++) begin
            fsw_live <= lcbv_fsw_t'(f);
            repeat (2) @(posedge core_clk);
            e = {d[15:12], 6'h00, lut(f), 1'b0, d[1:0]};
            acc(1'b0, LCBV_CMD_COMP, 16'h0000, {2'h2, e});
        end
        acc(1'b1, LCBV_CMD_COMP, 16'h0080, {2'h2, 16'h0000});
        acc(1'b0, LCBV_CMD_COMP, 16'h0000, {2'h2, 16'h00b8});
        for (int i = 0; i < 3; i++) begin
            soft_start <= i[0];
            d = (16'($random(seed)) & 16'hc000) | 16'(i);
            acc(1'b1, LCBV_CMD_BOOT, d, {2'h2, 16'h0000});
            acc(1'b0, LCBV_CMD_BOOT, 16'h0000, {2'h2, d});
            chk({7'h00, boot_dac_voltage_r}, {7'h00, dac(i)});
        end
        for (int b = 5; b < 14; b++) acc(1'b1, LCBV_CMD_BOOT, 16'h0001 | (16'h1 << b),
            {2'h1, 16'h0000});
        acc(1'b0, LCBV_CMD_BOOT, 16'h0000, {2'h2, d});
        soft_start <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            margin_sel <= 2'(m);
            mhi <= 11'($random(seed));
            mlo <= 11'($random(seed));
            trim <= 11'($random(seed));
            scale_mult <= 4'h1 << 2'($random(seed));
            repeat (5) @(posedge core_clk);
            s = ((m == 0) ? dac(2) : (m == 1) ? mhi : mlo) + trim;
            e = {5'h00, s} * {12'h000, scale_mult};
            chk({2'h0, boot_voltage_r}, {2'h0, e});
            chk({2'h0, ref_target_r}, {2'h0, e});
        end
        margin_sel <= 2'h0;
        trim <= 11'h000;
        scale_mult <= 4'h1;
        repeat (5) @(posedge core_clk);
        soft_start <= 1'b1;
        acc(1'b1, LCBV_CMD_BOOT, 16'h0001, {2'h2, 16'h0000});
        repeat (5600) @(posedge core_clk);
        chk({2'h0, ref_target_r}, {7'h00, dac(1)});
        u_lcbv_host.word(1'b1, 8'hd3, 16'h1234);
        repeat (4) @(posedge core_clk);
        report_and_stop();
    end
endmodule
